// >>> hdl/tdcsp_port.sv
module tdcsp_port #(
  parameter logic [4:0] REF_PULSES = tdcsp_pkg::INIT_REF_PULSES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sck,
  input wire logic ssn,
  input wire logic mosi,
  output logic miso_q,
  output logic miso_oe_n_q,
  output logic int_n_q,
  input wire logic refclk_pin,
  input wire logic [tdcsp_pkg::CH_NUM-1:0] ch_valid,
  input wire logic [tdcsp_pkg::CH_NUM*tdcsp_pkg::RESULT_BITS-1:0] ch_ref_index,
  input wire logic [tdcsp_pkg::CH_NUM*tdcsp_pkg::RESULT_BITS-1:0] ch_stop,
  output logic [tdcsp_pkg::CH_NUM-1:0] ch_pop_q,
  output logic por_pulse_q,
  output logic init_pulse_q,
  output logic measure_en_q,
  output logic stops_open_q,
  output logic [tdcsp_pkg::CFG_BYTES*8-1:0] cfg_q
);
  import tdcsp_pkg::*;

  // ==========================================================
  // link side, clocked by sck
  logic link_rst;
  tdcsp_link_type st_q;
  logic [2:0] bit_q;
  logic [6:0] rx_q;
  logic [6:0] tx_q;
  logic [4:0] addr_q;
  logic rd_res_q;
  logic por_tgl_q;
  logic init_tgl_q;
  logic [CH_NUM-1:0] pop_tgl_q;
  logic [7:0] cfg_mem [CFG_BYTES];
  logic [7:0] res_mem [RES_BYTES];
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] rd_data;

  // select high is the serial reset; sck idles low in mode 1
  assign link_rst = ssn | ~rstn;
  assign rx_byte = {rx_q, mosi};
  assign byte_done = (bit_q == 3'h7);

  // bit counter and input shifter, falling edge
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      bit_q <= 3'h0;
      rx_q <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      rx_q <= {rx_q[5:0], mosi};
    end
  end

  // opcode decode and auto-advancing address
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      st_q <= ST_OPCODE;
      addr_q <= 5'h00;
      rd_res_q <= 1'b0;
    end else if (byte_done) begin
      unique case (st_q)
        ST_OPCODE: begin
          addr_q <= rx_byte[4:0];
          if (rx_byte[7:5] == OP_WRITE) begin
            st_q <= ST_WRITE;
          end else if (rx_byte[7:5] == OP_RD_RES) begin
            st_q <= ST_READ;
            rd_res_q <= 1'b1;
          end else if (rx_byte[7:5] == OP_RD_CFG) begin
            st_q <= ST_READ;
          end else begin
            st_q <= ST_DONE; // trailing bytes after reset opcodes ignored
          end
        end
        ST_WRITE: addr_q <= addr_q + 5'h01;
        ST_READ: addr_q <= addr_q + 5'h01;
        ST_DONE: st_q <= ST_DONE;
      endcase
    end
  end

  // command events cross as toggles; only rstn clears them so a
  // select pulse cannot eat an event the clk side has not seen yet
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn) begin
      por_tgl_q <= 1'b0;
      init_tgl_q <= 1'b0;
    end else if (byte_done && st_q == ST_OPCODE) begin
      if (rx_byte == OP_POWER) begin
        por_tgl_q <= ~por_tgl_q;
      end
      if (rx_byte == OP_INIT) begin
        init_tgl_q <= ~init_tgl_q;
      end
    end
  end

  // last byte of a channel record shifted out pops that channel
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn) begin
      pop_tgl_q <= '0;
    end else if (byte_done && st_q == ST_READ && rd_res_q) begin
      for (int c = 0; c < CH_NUM; c++) begin
        if (addr_q == 5'(RES_FIRST + c * REC_BYTES + REC_BYTES - 1)) begin
          pop_tgl_q[c] <= ~pop_tgl_q[c];
        end
      end
    end
  end

  // configuration store; written only by complete bytes
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_mem[i] <= CFG_RESET;
      end
    end else if (byte_done) begin
      if (st_q == ST_OPCODE && rx_byte == OP_POWER) begin
        for (int i = 0; i < CFG_BYTES; i++) begin
          cfg_mem[i] <= CFG_RESET;
        end
      end else if (st_q == ST_WRITE && addr_q <= CFG_LAST) begin
        cfg_mem[addr_q] <= rx_byte;
      end
    end
  end

  // read mux; res_mem is frozen by the clk side while selected
  always_comb begin
    rd_data = 8'h00;
    if (rd_res_q) begin
      if (addr_q >= RES_FIRST) begin
        rd_data = res_mem[5'(addr_q - RES_FIRST)];
      end
    end else if (addr_q <= CFG_LAST) begin
      rd_data = cfg_mem[addr_q];
    end
  end

  // output shifter, rising edge; pin floats while select high
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
      tx_q <= 7'h00;
    end else begin
      miso_oe_n_q <= 1'b0;
      if (st_q == ST_READ && bit_q == 3'h0) begin
        {miso_q, tx_q} <= rd_data;
      end else begin
        {miso_q, tx_q} <= {tx_q, 1'b0};
      end
    end
  end

  // ==========================================================
  // system side, clocked by clk
  logic ssn_s1_q;
  logic ssn_s2_q;
  logic [2:0] por_s_q;
  logic [2:0] init_s_q;
  logic [2:0] ref_s_q;
  logic [2:0] pop_s_q [CH_NUM];
  logic [4:0] ref_cnt_q;
  logic [23:0] subdiv;
  logic por_ev;
  logic init_ev;
  logic ref_rise;

  // stop value saturates at subdivisions minus one
  function automatic logic [19:0] clamp_stop(input logic [19:0] v, input logic [23:0] div);
    logic [23:0] lim;
    lim = div - 24'h000001;
    if (div != 24'h000000 && {4'h0, v} > lim) begin
      clamp_stop = lim[19:0];
    end else begin
      clamp_stop = v;
    end
  endfunction : clamp_stop

  assign subdiv = cfg_q[DIV_BYTE0*8 +: 24];
  assign por_ev = por_s_q[1] ^ por_s_q[2];
  assign init_ev = init_s_q[1] ^ init_s_q[2];
  assign ref_rise = ref_s_q[1] & ~ref_s_q[2];

  // two-stage synchronisers plus one history stage for edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ssn_s1_q <= 1'b1;
      ssn_s2_q <= 1'b1;
      por_s_q <= 3'h0;
      init_s_q <= 3'h0;
      ref_s_q <= 3'h0;
      for (int c = 0; c < CH_NUM; c++) begin
        pop_s_q[c] <= 3'h0;
      end
    end else if (ce) begin
      ssn_s1_q <= ssn;
      ssn_s2_q <= ssn_s1_q;
      por_s_q <= {por_s_q[1:0], por_tgl_q};
      init_s_q <= {init_s_q[1:0], init_tgl_q};
      ref_s_q <= {ref_s_q[1:0], refclk_pin};
      for (int c = 0; c < CH_NUM; c++) begin
        pop_s_q[c] <= {pop_s_q[c][1:0], pop_tgl_q[c]};
      end
    end
  end

  // snapshots move only while the link is idle, so the sck side
  // sees stable words for a whole frame without a handshake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= '0;
    end else if (ce && ssn_s2_q) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_q[i*8 +: 8] <= cfg_mem[i];
      end
    end
  end

  // result records: index then stop, three bytes each, msb first;
  // output width settings deliberately play no part here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < RES_BYTES; i++) begin
        res_mem[i] <= 8'h00;
      end
    end else if (ce && ssn_s2_q) begin
      for (int c = 0; c < CH_NUM; c++) begin
        logic [19:0] ri;
        logic [19:0] sv;
        ri = ch_valid[c] ? ch_ref_index[c*RESULT_BITS +: RESULT_BITS] : EMPTY_MARK;
        sv = ch_valid[c] ? clamp_stop(ch_stop[c*RESULT_BITS +: RESULT_BITS], subdiv)
                         : EMPTY_MARK;
        res_mem[c*REC_BYTES] <= {4'h0, ri[19:16]};
        res_mem[c*REC_BYTES+1] <= ri[15:8];
        res_mem[c*REC_BYTES+2] <= ri[7:0];
        res_mem[c*REC_BYTES+3] <= {4'h0, sv[19:16]};
        res_mem[c*REC_BYTES+4] <= sv[15:8];
        res_mem[c*REC_BYTES+5] <= sv[7:0];
      end
    end
  end

  // command pulses and channel pops towards the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_pulse_q <= 1'b0;
      init_pulse_q <= 1'b0;
      ch_pop_q <= '0;
    end else if (ce) begin
      por_pulse_q <= por_ev;
      init_pulse_q <= init_ev;
      for (int c = 0; c < CH_NUM; c++) begin
        ch_pop_q[c] <= pop_s_q[c][1] ^ pop_s_q[c][2];
      end
    end
  end

  // measurement enable and delayed stop opening after init
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measure_en_q <= 1'b0;
      stops_open_q <= 1'b0;
      ref_cnt_q <= 5'h00;
    end else if (ce) begin
      if (por_ev) begin
        measure_en_q <= 1'b0;
        stops_open_q <= 1'b0;
        ref_cnt_q <= 5'h00;
      end else if (init_ev) begin
        measure_en_q <= 1'b1;
        stops_open_q <= 1'b0;
        ref_cnt_q <= 5'h00;
      end else if (measure_en_q && !stops_open_q && ref_rise) begin
        ref_cnt_q <= ref_cnt_q + 5'h01;
        if (ref_cnt_q + 5'h01 == REF_PULSES) begin
          stops_open_q <= 1'b1;
        end
      end
    end
  end

  // interrupt is low while any channel holds a result
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_n_q <= 1'b1;
    end else if (ce) begin
      int_n_q <= ~(|ch_valid);
    end
  end

endmodule : tdcsp_port

// >>> hdl/tdcsp_pkg.sv
// Function
// - link runs clock phase 1, polarity 0
// - select high holds serial logic in reset
// - data in sampled on falling edge, msb first
// - data out driven on rising edge, msb first
// - data out released while select high
// - interrupt low means results are waiting
// - opcode 30 resets config, stops measuring
// - opcode 18 restarts, keeps config and data
// - sixteen reference pulses before stops open
// - writes hit config only, opcode 80 plus address
// - further write bytes go to next register
// - read results 60, config 40, plus address
// - reads stream bytes, address advancing each byte
// - empty channel reads back as all ones
// - stop value counts reference period subdivisions
// - stop value saturates at subdivisions minus one
// - twenty result bits, top nibble reads zero
// - output width settings ignored for serial reads
// - interrupt returns high once all channels empty
package tdcsp_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_POWER = 8'h30;
  localparam logic [7:0] OP_INIT = 8'h18;
  localparam logic [2:0] OP_WRITE = 3'h4;
  localparam logic [2:0] OP_RD_RES = 3'h3;
  localparam logic [2:0] OP_RD_CFG = 3'h2;
  // ==========================================================
  // register space
  localparam int CFG_BYTES = 18;
  localparam logic [4:0] CFG_LAST = 5'h11;
  localparam logic [4:0] RES_FIRST = 5'h08;
  localparam int CH_NUM = 4;
  localparam int REC_BYTES = 6;
  localparam int RES_BYTES = 24;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // subdivision count bytes, low byte first
  localparam int DIV_BYTE0 = 3;
  // ==========================================================
  // result coding and timing
  localparam int RESULT_BITS = 20;
  localparam logic [19:0] EMPTY_MARK = 20'hFFFFF;
  localparam logic [4:0] INIT_REF_PULSES = 5'h10;
  // ==========================================================
  // link byte phase
  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_DONE = 4'b1000
  } tdcsp_link_type;
endpackage : tdcsp_pkg

// >>> testbench/tdcsp_port_monitor.sv
module tdcsp_port_monitor #(
  parameter logic [4:0] REF_PULSES = tdcsp_pkg::INIT_REF_PULSES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ssn,
  input wire logic miso_oe_n_q,
  input wire logic int_n_q,
  input wire logic [tdcsp_pkg::CH_NUM-1:0] ch_valid,
  input wire logic [tdcsp_pkg::CH_NUM-1:0] ch_pop_q,
  input wire logic por_pulse_q,
  input wire logic init_pulse_q,
  input wire logic measure_en_q,
  input wire logic stops_open_q,
  input wire logic [tdcsp_pkg::CFG_BYTES*8-1:0] cfg_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import tdcsp_pkg::*;
  // ==========
  // port checks, all on the system clock
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // stops must stay shut for four cycles, starting two cycles after the init pulse
  sequence s_closed;
    !stops_open_q [*4];
  endsequence
  sequence s_busy;
    !ssn [*5];
  endsequence
  a_init_starts: assert property (init_pulse_q |-> ##[0:1] measure_en_q)
    else $error("init did not start measuring");
  a_init_closes: assert property (init_pulse_q |-> ##2 s_closed)
    else $error("stops opened too early");
  a_por_stops: assert property (por_pulse_q |-> ##[0:1] !measure_en_q)
    else $error("power reset left measuring on");
  a_int_low: assert property (ch_valid != '0 |=> !int_n_q)
    else $error("interrupt not low with data");
  a_int_high: assert property (ch_valid == '0 |=> int_n_q)
    else $error("interrupt low with all empty");
  a_miso_idle: assert property (ssn |-> miso_oe_n_q)
    else $error("miso driven while deselected");
  a_pop_single: assert property (ch_pop_q != '0 |-> $onehot(ch_pop_q) ##1 ch_pop_q == '0)
    else $error("bad pop pulse");
  a_cfg_frozen: assert property (s_busy |-> $stable(cfg_q))
    else $error("config changed mid frame");
endmodule : tdcsp_port_monitor

bind tdcsp_port tdcsp_port_monitor #(.REF_PULSES(REF_PULSES)) u_mon (.clk, .rstn, .ssn,
  .miso_oe_n_q, .int_n_q, .ch_valid, .ch_pop_q, .por_pulse_q, .init_pulse_q, .measure_en_q,
  .stops_open_q, .cfg_q);

// >>> testbench/tdcsp_host.sv
module tdcsp_host (
  output logic sck,
  output logic ssn,
  output logic mosi,
  input wire logic miso_q,
  input wire logic miso_oe_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // master end of the link; no pull on miso, so a released line reads
  // inverted and a late sample cannot pass by luck
  wire miso = miso_oe_n_q ? ~miso_q : miso_q;
  // idle levels at time zero
  initial begin
    sck = 1'b0;
    ssn = 1'b1;
    mosi = 1'b0;
  end
  // one access, 48 ns clock only inside it; cut aborts mid-byte
  task automatic frame(input logic [7:0] tx[$], input int cut, output logic [7:0] rx[$]);
    logic [7:0] b;
    int n;
    n = tx.size() * 8 - cut;
    rx = {};
    ssn = 1'b1;
    #100 ssn = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      mosi = tx[i / 8][7 - i % 8];
      #24 sck = 1'b0;
      b[7 - i % 8] = miso;
      if (i % 8 == 7) rx.push_back(b);
      #24;
    end
    #100 ssn = 1'b1;
    mosi = ~mosi; // no stale level on a dead line
  endtask : frame
endmodule : tdcsp_host

// >>> testbench/tb_tdc_spi_command_port.sv
module tb_tdc_spi_command_port;
  timeunit 1ns;
  timeprecision 1ps;
  import tdcsp_pkg::*;
  logic clk = 1'b0;
  logic refclk_pin = 1'b0;
  logic rstn;
  logic [CH_NUM-1:0] ch_valid;
  logic [CH_NUM*RESULT_BITS-1:0] ch_ref_index;
  logic [CH_NUM*RESULT_BITS-1:0] ch_stop;
  wire sck, ssn, mosi, miso_q, miso_oe_n_q, int_n_q;
  wire por_pulse_q, init_pulse_q, measure_en_q, stops_open_q;
  wire [CH_NUM-1:0] ch_pop_q;
  wire [CFG_BYTES*8-1:0] cfg_q;
  logic [7:0] rx[$];
  int fail_count = 0;
  int cmp_count = 0;
  logic [CH_NUM-1:0] pop_seen = '0;
  int por_seen = 0;
  int init_seen = 0;
  // ==========
  // clocks; reference clock slow so the pulse count is visible
  always #10 clk = ~clk;
  always #200 refclk_pin = ~refclk_pin;
  tdcsp_port #(.REF_PULSES(5'h02)) u_dut (.clk, .rstn, .ce(1'b1), .sck, .ssn, .mosi, .miso_q,
    .miso_oe_n_q, .int_n_q, .refclk_pin, .ch_valid, .ch_ref_index, .ch_stop, .ch_pop_q,
    .por_pulse_q, .init_pulse_q, .measure_en_q, .stops_open_q, .cfg_q);
  tdcsp_host u_host (.sck, .ssn, .mosi, .miso_q, .miso_oe_n_q);
  // pulse outputs are gathered so the scenarios can count them
  always @(posedge clk) begin
    pop_seen <= pop_seen | ch_pop_q;
    if (por_pulse_q) por_seen <= por_seen + 1;
    if (init_pulse_q) init_seen <= init_seen + 1;
  end
  // ==========
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] st();
    return {4'h0, int_n_q, measure_en_q, miso_oe_n_q, stops_open_q};
  endfunction : st
  // whole frame, then the settle wait before talking again
  task automatic go(input logic [7:0] tx[$]);
    u_host.frame(tx, 0, rx);
    repeat (8) @(posedge clk);
  endtask : go
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // ==========
  // scenarios
  task automatic t_write;
    go({8'h90, 8'hA5, 8'h3C, 8'h77});
    check(cfg_q[128+:8], 8'hA5);
    check(cfg_q[136+:8], 8'h3C);
    u_host.frame({8'h90, 8'h11}, 3, rx);
    repeat (8) @(posedge clk);
    check(cfg_q[128+:8], 8'hA5);
    go({8'h50, 8'h00, 8'h00, 8'h00});
    check(rx[1], 8'hA5);
    check(rx[2], 8'h3C);
    check(rx[3], 8'h00);
  endtask : t_write
  // 256 subdivisions; channel 1 empty, channel 2 stop above range
  task automatic t_results;
    logic [7:0] q[$];
    logic [7:0] e[18] = '{8'h01, 8'h23, 8'h45, 8'h00, 8'h00, 8'h42, 8'h0F, 8'hFF, 8'hFF,
      8'h0F, 8'hFF, 8'hFF, 8'h0A, 8'hBC, 8'hDE, 8'h00, 8'h00, 8'hFF};
    q = {8'h80};
    repeat (CFG_BYTES) q.push_back(8'h00);
    q[5] = 8'h01; // subdivisions 256
    q[17] = 8'hA5;
    q[18] = 8'h3C;
    go(q);
    @(posedge clk);
    ch_valid <= 4'b0101;
    ch_ref_index <= {20'h0, 20'hABCDE, 20'h0, 20'h12345};
    ch_stop <= {20'h0, 20'h00300, 20'h0, 20'h00042};
    repeat (3) @(posedge clk);
    check(st(), 8'h02);
    check(8'(pop_seen), 8'h00);
    q = {8'h68};
    repeat (18) q.push_back(8'h00);
    go(q);
    foreach (e[i]) check(rx[i + 1], e[i]);
    check(8'(pop_seen), 8'h07);
    ch_valid <= '0;
    repeat (3) @(posedge clk);
    check(st(), 8'h0A);
  endtask : t_results
  task automatic t_cmds;
    go({8'h18});
    check(st(), 8'h0E);
    check(8'(init_seen), 8'h01);
    check(cfg_q[128+:8], 8'hA5);
    repeat (60) @(posedge clk);
    check(st(), 8'h0F);
    go({8'h30});
    check(st(), 8'h0A);
    check(8'(por_seen), 8'h01);
    check(8'(cfg_q == '0), 8'h01);
  endtask : t_cmds
  // watchdog, run needs about 24 us
  initial begin
    #200000;
    fail_count++;
    results();
  end
  // reset, then the scenarios in order
  initial begin
    rstn = 1'b0;
    ch_valid = '0;
    ch_ref_index = '0;
    ch_stop = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    check(st(), 8'h0A);
    t_write();
    t_results();
    t_cmds();
    results();
  end
endmodule : tb_tdc_spi_command_port
